// [bench/tb_top.sv]
/*
 Self-checking bench for the fault check enable bank.
 Assumes the design package and a 200 MHz single clock domain.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_top
	import fault_check_pkg::*;
;
	// ------------------------------------------------------------
	// Signals
	// ------------------------------------------------------------
	logic              aclk, aresetn;
	logic [ADDR_W-1:0] awaddr, araddr;
	logic              awvalid, awready, wvalid, wready, bvalid, bready;
	logic              arvalid, arready, rvalid, rready;
	logic [31:0]       wdata, rdata;
	logic [3:0]        wstrb;
	logic [1:0]        bresp, rresp;
	logic              meas_valid;
	meas_kind_t        meas_kind;
	logic [CH_W-1:0]   meas_channel;
	logic [VAL_W-1:0]  meas_adc, meas_comp;
	logic [VAL_W-1:0]  th_bo, th_bu, th_co, th_coc, th_cu, th_cuc;
	logic [VAL_W-1:0]  th_ar, th_aa, th_arc, th_aac;
	logic              block_over_alert, block_under_alert, irq;
	logic [CELL_N-1:0] cell_over_alert, cell_under_alert;
	logic [AUX_N-1:0]  aux_over_alert;
	int                err_total, comparisons;

	fault_check_top i_dut (
		.aclk(aclk), .aresetn(aresetn),
		.awaddr(awaddr), .awvalid(awvalid), .awready(awready),
		.wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
		.bresp(bresp), .bvalid(bvalid), .bready(bready),
		.araddr(araddr), .arvalid(arvalid), .arready(arready),
		.rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
		.meas_valid(meas_valid), .meas_kind(meas_kind),
		.meas_channel(meas_channel), .meas_adc(meas_adc),
		.meas_comp(meas_comp),
		.block_over_threshold(th_bo), .block_under_threshold(th_bu),
		.cell_over_threshold_adc(th_co),
		.cell_over_threshold_comparator(th_coc),
		.cell_under_threshold_adc(th_cu),
		.cell_under_threshold_comparator(th_cuc),
		.aux_ratio_over_threshold(th_ar),
		.aux_absolute_over_threshold(th_aa),
		.aux_ratio_over_threshold_comparator(th_arc),
		.aux_absolute_over_threshold_comparator(th_aac),
		.block_over_alert(block_over_alert),
		.block_under_alert(block_under_alert),
		.cell_over_alert(cell_over_alert),
		.cell_under_alert(cell_under_alert),
		.aux_over_alert(aux_over_alert), .irq(irq)
	);

	// ------------------------------------------------------------
	// Clock and closing
	// ------------------------------------------------------------
	always #2.5 aclk = ~aclk;

	task automatic finish_test();
		$display("comparisons %0d, mismatches %0d", comparisons, err_total);
		if (err_total == 0 && comparisons > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	// Watchdog: the whole sequence needs well under 2000 cycles
	initial begin
		repeat (20000) @(posedge aclk);
		err_total++;
		finish_test();
	end

	// ------------------------------------------------------------
	// Access tasks
	// ------------------------------------------------------------
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			err_total++;
			$display("[ERR] %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// Address and data offered together; each released once taken
	task automatic wr(input logic [IDX_W-1:0] idx, input logic [15:0] d,
		input logic [1:0] er);
		logic aw_ok, w_ok;
		aw_ok = 1'b0;
		w_ok = 1'b0;
		@(posedge aclk);
		awaddr <= {idx, 2'b00};
		wdata <= {16'h0000, d};
		wstrb <= 4'hf;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!(aw_ok && w_ok)) begin
			@(posedge aclk);
			if (!aw_ok && awready === 1'b1) begin
				aw_ok = 1'b1;
				awvalid <= 1'b0;
			end
			if (!w_ok && wready === 1'b1) begin
				w_ok = 1'b1;
				wvalid <= 1'b0;
			end
		end
		do @(posedge aclk); while (bvalid !== 1'b1);
		chk(32'(bresp), 32'(er));
		bready <= 1'b0;
	endtask

	task automatic rd(input logic [IDX_W-1:0] idx, input logic [15:0] d,
		input logic [1:0] er);
		@(posedge aclk);
		araddr <= {idx, 2'b00};
		arvalid <= 1'b1;
		rready <= 1'b1;
		do @(posedge aclk); while (arready !== 1'b1);
		arvalid <= 1'b0;
		do @(posedge aclk); while (rvalid !== 1'b1);
		chk(rdata, {16'h0000, d});
		chk(32'(rresp), 32'(er));
		rready <= 1'b0;
	endtask

	// One measurement strobe; alerts are looked at once it has landed
	task automatic meas(input meas_kind_t k, input logic [CH_W-1:0] ch,
		input logic [15:0] a, input logic [15:0] c);
		@(posedge aclk);
		meas_valid <= 1'b1;
		meas_kind <= k;
		meas_channel <= ch;
		meas_adc <= a;
		meas_comp <= c;
		@(posedge aclk);
		meas_valid <= 1'b0;
		#1;
	endtask

	// irq is registered on the same edge as the status
	task automatic irq_chk(input logic e);
		repeat (2) @(posedge aclk);
		#1;
		chk(32'(irq), 32'(e));
	endtask

	// ------------------------------------------------------------
	// Tests
	// ------------------------------------------------------------
	initial begin
		aclk = 1'b0;
		err_total = 0;
		comparisons = 0;
		aresetn <= 1'b0;
		{awvalid, wvalid, bready, arvalid, rready, meas_valid} <= '0;
		awaddr <= '0;
		araddr <= '0;
		wdata <= '0;
		wstrb <= '0;
		meas_kind <= MEAS_NONE;
		meas_channel <= '0;
		meas_adc <= '0;
		meas_comp <= '0;
		// Distinct ratiometric and absolute levels tell the two apart
		{th_bo, th_bu, th_co, th_coc} <= {4{16'h8000}};
		{th_cu, th_cuc} <= {2{16'h1000}};
		{th_ar, th_arc, th_aa, th_aac} <= {16'h1000, 16'h1000, 16'h3000, 16'h3000};
		repeat (8) @(posedge aclk);
		aresetn <= 1'b1;
		// Reset values, read/write and unused bits
		rd(IDX_OV_EN, 16'h0000, RESP_OKAY);
		rd(IDX_UV_EN, 16'h0000, RESP_OKAY);
		rd(IDX_AUX_EN, 16'h0000, RESP_OKAY);
		wr(IDX_OV_EN, 16'hffff, RESP_OKAY);
		rd(IDX_OV_EN, 16'h7fff, RESP_OKAY);
		wr(IDX_UV_EN, 16'hffff, RESP_OKAY);
		rd(IDX_UV_EN, 16'h7fff, RESP_OKAY);
		wr(IDX_AUX_EN, 16'hffff, RESP_OKAY);
		rd(IDX_AUX_EN, 16'h003f, RESP_OKAY);
		wr(6'h3f, 16'h1234, RESP_SLVERR);
		rd(6'h3f, 16'h0000, RESP_SLVERR);
		wr(IDX_OV_ADC, 16'h1234, RESP_SLVERR);
		wr(IDX_IRQ_MASK, 16'h001f, RESP_OKAY);
		// Cell overvoltage on both paths; the threshold itself is no fault
		meas(MEAS_CELL, 4'd3, 16'h9000, 16'h4000);
		chk(32'(cell_over_alert), 32'h0008);
		irq_chk(1'b1);
		meas(MEAS_CELL, 4'd13, 16'h4000, 16'h9000);
		meas(MEAS_CELL, 4'd7, 16'h8000, 16'h8000);
		chk(32'(cell_over_alert), 32'h2008);
		wr(IDX_OV_EN, 16'h7ff7, RESP_OKAY);
		meas(MEAS_CELL, 4'd3, 16'h9000, 16'h4000);
		chk(32'(cell_over_alert), 32'h2000);
		rd(IDX_OV_ADC, 16'h0000, RESP_OKAY);
		rd(IDX_OV_CMP, 16'h2000, RESP_OKAY);
		// Cell undervoltage on both paths, then one bit cleared
		meas(MEAS_CELL, 4'd0, 16'h0800, 16'h4000);
		meas(MEAS_CELL, 4'd13, 16'h4000, 16'h0800);
		chk(32'(cell_under_alert), 32'h2001);
		wr(IDX_UV_EN, 16'h7ffe, RESP_OKAY);
		chk(32'(cell_under_alert), 32'h2000);
		// Block checks use the converter result only
		meas(MEAS_BLOCK, 4'd0, 16'h4000, 16'hffff);
		chk(32'(block_over_alert), 32'h0);
		meas(MEAS_BLOCK, 4'd0, 16'h9000, 16'h4000);
		chk(32'(block_over_alert), 32'h1);
		meas(MEAS_BLOCK, 4'd0, 16'h0800, 16'h4000);
		chk(32'(block_under_alert), 32'h1);
		wr(IDX_OV_EN, 16'h3ff7, RESP_OKAY);
		chk(32'(block_over_alert), 32'h0);
		wr(IDX_UV_EN, 16'h3ffe, RESP_OKAY);
		chk(32'(block_under_alert), 32'h0);
		// Interrupt status is sticky and cleared by writing ones
		rd(IDX_IRQ_STAT, 16'h000f, RESP_OKAY);
		wr(IDX_IRQ_STAT, 16'h000f, RESP_OKAY);
		rd(IDX_IRQ_STAT, 16'h0000, RESP_OKAY);
		irq_chk(1'b0);
		// Auxiliary: channel 0 ratiometric, others absolute, 3 in pin mode
		wr(IDX_AUX_CFG, 16'h0801, RESP_OKAY);
		meas(MEAS_AUX, 4'd0, 16'h2000, 16'h0000);
		meas(MEAS_AUX, 4'd1, 16'h2000, 16'h0000);
		chk(32'(aux_over_alert), 32'h01);
		meas(MEAS_AUX, 4'd5, 16'h3800, 16'h0000);
		meas(MEAS_AUX, 4'd2, 16'h0000, 16'h3800);
		chk(32'(aux_over_alert), 32'h25);
		meas(MEAS_AUX, 4'd3, 16'hffff, 16'hffff);
		chk(32'(aux_over_alert), 32'h25);
		rd(IDX_AUX_EN, 16'h003f, RESP_OKAY);
		wr(IDX_AUX_EN, 16'h003e, RESP_OKAY);
		chk(32'(aux_over_alert), 32'h24);
		rd(IDX_AUX_ALR, 16'h0420, RESP_OKAY);
		// Masking holds the line low while the status stays set
		wr(IDX_IRQ_MASK, 16'h0000, RESP_OKAY);
		irq_chk(1'b0);
		rd(IDX_IRQ_STAT, 16'h0010, RESP_OKAY);
		wr(IDX_IRQ_MASK, 16'h0010, RESP_OKAY);
		irq_chk(1'b1);
		wr(IDX_IRQ_STAT, 16'h0010, RESP_OKAY);
		irq_chk(1'b0);
		finish_test();
	end
endmodule // tb_top
`default_nettype wire

// [verilog/axil_slave.sv]
/*
 AXI4-Lite slave front end: one write and one read at a time.
 Assumes a master that keeps AXI valid/payload rules.
*/
`timescale 1ns/1ps
`default_nettype none
module axil_slave
	import fault_check_pkg::*;
(
	// Clock and reset
	input  wire logic              aclk,
	input  wire logic              aresetn,
	// Write channels
	input  wire logic [ADDR_W-1:0] awaddr,
	input  wire logic              awvalid,
	output var  logic              awready,
	input  wire logic [31:0]       wdata,
	input  wire logic [3:0]        wstrb,
	input  wire logic              wvalid,
	output var  logic              wready,
	output var  logic [1:0]        bresp,
	output var  logic              bvalid,
	input  wire logic              bready,
	// Read channels
	input  wire logic [ADDR_W-1:0] araddr,
	input  wire logic              arvalid,
	output var  logic              arready,
	output var  logic [31:0]       rdata,
	output var  logic [1:0]        rresp,
	output var  logic              rvalid,
	input  wire logic              rready,
	// Register bank side
	reg_access_if.bus              ra
);
	logic [ADDR_W-1:0] aw_reg;
	logic              aw_held;
	logic              w_held;
	logic [31:0]       wd_reg;
	logic [3:0]        ws_reg;
	wire aw_take = awvalid && awready;
	wire w_take = wvalid && wready;
	wire do_wr = aw_held && w_held && !bvalid;
	wire ar_take = arvalid && arready;

	// Decode wires towards the bank; misaligned writes miss, reads ignore the low address bits
	assign ra.wr_en = do_wr;
	assign ra.wr_idx = aw_reg[ADDR_W-1:2];
	assign ra.wr_data = wd_reg;
	assign ra.wr_strb = (aw_reg[1:0] == 2'h0) ? ws_reg : 4'h0;
	assign ra.rd_idx = araddr[ADDR_W-1:2];

	// Write address and data are taken independently, in either order
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			awready <= 1'b0;
			wready <= 1'b0;
			aw_held <= 1'b0;
			w_held <= 1'b0;
			aw_reg <= '0;
			wd_reg <= '0;
			ws_reg <= 4'h0;
			bvalid <= 1'b0;
			bresp <= RESP_OKAY;
		end else begin
			awready <= awvalid && !awready && !aw_held;
			wready <= wvalid && !wready && !w_held;
			if (aw_take) begin
				aw_held <= 1'b1;
				aw_reg <= awaddr;
			end
			if (w_take) begin
				w_held <= 1'b1;
				wd_reg <= wdata;
				ws_reg <= wstrb;
			end
			if (do_wr) begin
				aw_held <= 1'b0;
				w_held <= 1'b0;
				bvalid <= 1'b1;
				bresp <= (ra.wr_hit && aw_reg[1:0] == 2'h0) ?
					RESP_OKAY : RESP_SLVERR;
			end else if (bvalid && bready) begin
				bvalid <= 1'b0;
			end
		end
	end

	// Read data is captured on the accepting edge; unmapped reads zero
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready <= 1'b0;
			rvalid <= 1'b0;
			rdata <= '0;
			rresp <= RESP_OKAY;
		end else begin
			arready <= arvalid && !arready && !rvalid;
			if (ar_take) begin
				rvalid <= 1'b1;
				rdata <= ra.rd_hit ? ra.rd_data : 32'h0;
				rresp <= ra.rd_hit ? RESP_OKAY : RESP_SLVERR;
			end else if (rvalid && rready) begin
				rvalid <= 1'b0;
			end
		end
	end
endmodule // axil_slave
`default_nettype wire

// [verilog/fault_check_pkg.sv]
/*
 Constants, register map and types of the fault check enable bank.
 Assumes a 32-bit AXI4-Lite bus with byte addresses equal to four times
 the register index.
*/
`default_nettype none
package fault_check_pkg;
	// ------------------------------------------------------------
	// Sizes
	// ------------------------------------------------------------
	localparam int ADDR_W = 8;
	localparam int IDX_W = 6;
	localparam int CELL_N = 14;
	localparam int AUX_N = 6;
	localparam int CH_W = 4;
	localparam int VAL_W = 16;
	localparam int BLOCK_BIT = 14;
	// ------------------------------------------------------------
	// Register indices (byte address is four times the index)
	// ------------------------------------------------------------
	localparam logic [IDX_W-1:0] IDX_OV_EN = 6'h1a;
	localparam logic [IDX_W-1:0] IDX_UV_EN = 6'h1b;
	localparam logic [IDX_W-1:0] IDX_AUX_EN = 6'h1c;
	localparam logic [IDX_W-1:0] IDX_AUX_CFG = 6'h20;
	localparam logic [IDX_W-1:0] IDX_IRQ_STAT = 6'h21;
	localparam logic [IDX_W-1:0] IDX_IRQ_MASK = 6'h22;
	localparam logic [IDX_W-1:0] IDX_OV_ADC = 6'h23;
	localparam logic [IDX_W-1:0] IDX_OV_CMP = 6'h24;
	localparam logic [IDX_W-1:0] IDX_UV_ADC = 6'h25;
	localparam logic [IDX_W-1:0] IDX_UV_CMP = 6'h26;
	localparam logic [IDX_W-1:0] IDX_AUX_ALR = 6'h27;
	// ------------------------------------------------------------
	// Field masks, reset values, fields
	// ------------------------------------------------------------
	localparam logic [15:0] CELL_EN_MASK = 16'h7fff;
	localparam logic [15:0] AUX_EN_MASK = 16'h003f;
	localparam logic [15:0] AUX_CFG_MASK = 16'h3f3f;
	localparam logic [15:0] IRQ_MASK = 16'h001f;
	localparam logic [15:0] REG_RESET = 16'h0000;
	localparam int PIN_MODE_LSB = 8;
	localparam int IRQ_BOV = 0;
	localparam int IRQ_BUV = 1;
	localparam int IRQ_COV = 2;
	localparam int IRQ_CUV = 3;
	localparam int IRQ_AOV = 4;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// Kind of a scan measurement presented on the measurement port
	typedef enum logic [1:0] {MEAS_CELL, MEAS_BLOCK, MEAS_AUX, MEAS_NONE}
		meas_kind_t;
endpackage
`default_nettype wire

// [verilog/fault_check_top.sv]
/*
 Fault check enable bank with scan-time over/undervoltage checking,
 pending alerts and a maskable interrupt.
 Assumes scan measurements arrive one per strobe and thresholds are held
 steady by the threshold registers outside this block.
*/
// The AXI4-Lite interface to the registers is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
module fault_check_top
	import fault_check_pkg::*;
(
	// Clock and reset
	input  wire logic              aclk,
	input  wire logic              aresetn,
	// AXI4-Lite write
	input  wire logic [ADDR_W-1:0] awaddr,
	input  wire logic              awvalid,
	output var  logic              awready,
	input  wire logic [31:0]       wdata,
	input  wire logic [3:0]        wstrb,
	input  wire logic              wvalid,
	output var  logic              wready,
	output var  logic [1:0]        bresp,
	output var  logic              bvalid,
	input  wire logic              bready,
	// AXI4-Lite read
	input  wire logic [ADDR_W-1:0] araddr,
	input  wire logic              arvalid,
	output var  logic              arready,
	output var  logic [31:0]       rdata,
	output var  logic [1:0]        rresp,
	output var  logic              rvalid,
	input  wire logic              rready,
	// Scan measurement port
	input  wire logic              meas_valid,
	input  wire meas_kind_t        meas_kind,
	input  wire logic [CH_W-1:0]   meas_channel,
	input  wire logic [VAL_W-1:0]  meas_adc,
	input  wire logic [VAL_W-1:0]  meas_comp,
	// Thresholds
	input  wire logic [VAL_W-1:0]  block_over_threshold,
	input  wire logic [VAL_W-1:0]  block_under_threshold,
	input  wire logic [VAL_W-1:0]  cell_over_threshold_adc,
	input  wire logic [VAL_W-1:0]  cell_over_threshold_comparator,
	input  wire logic [VAL_W-1:0]  cell_under_threshold_adc,
	input  wire logic [VAL_W-1:0]  cell_under_threshold_comparator,
	input  wire logic [VAL_W-1:0]  aux_ratio_over_threshold,
	input  wire logic [VAL_W-1:0]  aux_absolute_over_threshold,
	input  wire logic [VAL_W-1:0]  aux_ratio_over_threshold_comparator,
	input  wire logic [VAL_W-1:0]  aux_absolute_over_threshold_comparator,
	// Alerts and interrupt
	output var  logic              block_over_alert,
	output var  logic              block_under_alert,
	output var  logic [CELL_N-1:0] cell_over_alert,
	output var  logic [CELL_N-1:0] cell_under_alert,
	output var  logic [AUX_N-1:0]  aux_over_alert,
	output var  logic              irq
);
	reg_access_if ra ();

	axil_slave u_axil (
		.aclk    (aclk),
		.aresetn (aresetn),
		.awaddr  (awaddr),
		.awvalid (awvalid),
		.awready (awready),
		.wdata   (wdata),
		.wstrb   (wstrb),
		.wvalid  (wvalid),
		.wready  (wready),
		.bresp   (bresp),
		.bvalid  (bvalid),
		.bready  (bready),
		.araddr  (araddr),
		.arvalid (arvalid),
		.arready (arready),
		.rdata   (rdata),
		.rresp   (rresp),
		.rvalid  (rvalid),
		.rready  (rready),
		.ra      (ra)
	);

	// ------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------
	logic [15:0]       ov_en_reg;
	logic [15:0]       uv_en_reg;
	logic [15:0]       aux_en_reg;
	logic [15:0]       aux_cfg_reg;
	logic [15:0]       irq_stat_reg;
	logic [15:0]       irq_mask_reg;
	logic [CELL_N-1:0] cov_adc_reg;
	logic [CELL_N-1:0] cov_cmp_reg;
	logic [CELL_N-1:0] cuv_adc_reg;
	logic [CELL_N-1:0] cuv_cmp_reg;
	logic              bov_reg;
	logic              buv_reg;
	logic [AUX_N-1:0]  aov_adc_reg;
	logic [AUX_N-1:0]  aov_cmp_reg;

	// ------------------------------------------------------------
	// Write decode
	// ------------------------------------------------------------
	wire [15:0] lane = {{8{ra.wr_strb[1]}}, {8{ra.wr_strb[0]}}};
	wire [15:0] wd16 = ra.wr_data[15:0];
	wire wr_ov = ra.wr_en && ra.wr_idx == IDX_OV_EN;
	wire wr_uv = ra.wr_en && ra.wr_idx == IDX_UV_EN;
	wire wr_aux = ra.wr_en && ra.wr_idx == IDX_AUX_EN;
	wire wr_cfg = ra.wr_en && ra.wr_idx == IDX_AUX_CFG;
	wire wr_stat = ra.wr_en && ra.wr_idx == IDX_IRQ_STAT;
	wire wr_mask = ra.wr_en && ra.wr_idx == IDX_IRQ_MASK;
	assign ra.wr_hit = (ra.wr_idx == IDX_OV_EN) ||
		(ra.wr_idx == IDX_UV_EN) || (ra.wr_idx == IDX_AUX_EN) ||
		(ra.wr_idx == IDX_AUX_CFG) || (ra.wr_idx == IDX_IRQ_STAT) ||
		(ra.wr_idx == IDX_IRQ_MASK);

	// Byte-lane merge; the field mask keeps unused bits at zero
	wire [15:0] ov_en_next = wr_ov ?
		((ov_en_reg & ~lane) | (wd16 & lane)) & CELL_EN_MASK :
		ov_en_reg;
	wire [15:0] uv_en_next = wr_uv ?
		((uv_en_reg & ~lane) | (wd16 & lane)) & CELL_EN_MASK :
		uv_en_reg;
	wire [15:0] aux_en_next = wr_aux ?
		((aux_en_reg & ~lane) | (wd16 & lane)) & AUX_EN_MASK :
		aux_en_reg;
	wire [15:0] aux_cfg_next = wr_cfg ?
		((aux_cfg_reg & ~lane) | (wd16 & lane)) & AUX_CFG_MASK :
		aux_cfg_reg;
	wire [15:0] irq_mask_next = wr_mask ?
		((irq_mask_reg & ~lane) | (wd16 & lane)) & IRQ_MASK :
		irq_mask_reg;

	// ------------------------------------------------------------
	// Scan checks
	// ------------------------------------------------------------
	wire cell_meas = meas_valid && meas_kind == MEAS_CELL;
	wire blk_meas = meas_valid && meas_kind == MEAS_BLOCK;
	wire aux_meas = meas_valid && meas_kind == MEAS_AUX;
	wire [AUX_N-1:0] aux_refsel = aux_cfg_reg[AUX_N-1:0];
	wire [AUX_N-1:0] aux_pin_io_mode =
		aux_cfg_reg[PIN_MODE_LSB +: AUX_N];
	logic [CELL_N-1:0] cov_adc_set;
	logic [CELL_N-1:0] cov_cmp_set;
	logic [CELL_N-1:0] cuv_adc_set;
	logic [CELL_N-1:0] cuv_cmp_set;
	logic [AUX_N-1:0]  aov_adc_set;
	logic [AUX_N-1:0]  aov_cmp_set;

	// Block path is ADC only
	wire bov_set = blk_meas && ov_en_reg[BLOCK_BIT] &&
		meas_adc > block_over_threshold;
	wire buv_set = blk_meas && uv_en_reg[BLOCK_BIT] &&
		meas_adc < block_under_threshold;

	// One check per cell channel against ADC and comparator thresholds
	for (genvar n = 0; n < CELL_N; n++) begin : g_cell
		wire hit = cell_meas && meas_channel == CH_W'(n);
		assign cov_adc_set[n] = hit && ov_en_reg[n] &&
			meas_adc > cell_over_threshold_adc;
		assign cov_cmp_set[n] = hit && ov_en_reg[n] &&
			meas_comp > cell_over_threshold_comparator;
		assign cuv_adc_set[n] = hit && uv_en_reg[n] &&
			meas_adc < cell_under_threshold_adc;
		assign cuv_cmp_set[n] = hit && uv_en_reg[n] &&
			meas_comp < cell_under_threshold_comparator;
	end

	// Pin-mode channels skip the check; the enable still reads back
	for (genvar n = 0; n < AUX_N; n++) begin : g_aux
		wire hit = aux_meas && meas_channel == CH_W'(n);
		wire live = aux_en_reg[n] && !aux_pin_io_mode[n];
		wire [VAL_W-1:0] th_adc = aux_refsel[n] ?
			aux_ratio_over_threshold :
			aux_absolute_over_threshold;
		wire [VAL_W-1:0] th_cmp = aux_refsel[n] ?
			aux_ratio_over_threshold_comparator :
			aux_absolute_over_threshold_comparator;
		assign aov_adc_set[n] = hit && live && meas_adc > th_adc;
		assign aov_cmp_set[n] = hit && live && meas_comp > th_cmp;
	end

	// ------------------------------------------------------------
	// Pending alerts: the new enable value gates them, so a write that
	// clears an enable clears its alert on the same edge
	// ------------------------------------------------------------
	wire bov_next = (bov_reg | bov_set) & ov_en_next[BLOCK_BIT];
	wire buv_next = (buv_reg | buv_set) & uv_en_next[BLOCK_BIT];
	wire [CELL_N-1:0] cov_adc_next =
		(cov_adc_reg | cov_adc_set) & ov_en_next[CELL_N-1:0];
	wire [CELL_N-1:0] cov_cmp_next =
		(cov_cmp_reg | cov_cmp_set) & ov_en_next[CELL_N-1:0];
	wire [CELL_N-1:0] cuv_adc_next =
		(cuv_adc_reg | cuv_adc_set) & uv_en_next[CELL_N-1:0];
	wire [CELL_N-1:0] cuv_cmp_next =
		(cuv_cmp_reg | cuv_cmp_set) & uv_en_next[CELL_N-1:0];
	wire [AUX_N-1:0] aov_adc_next =
		(aov_adc_reg | aov_adc_set) & aux_en_next[AUX_N-1:0];
	wire [AUX_N-1:0] aov_cmp_next =
		(aov_cmp_reg | aov_cmp_set) & aux_en_next[AUX_N-1:0];

	// Sticky interrupt status, write one to clear; a new event wins
	wire [15:0] irq_ev = 16'({|(aov_adc_set | aov_cmp_set),
		|(cuv_adc_set | cuv_cmp_set), |(cov_adc_set | cov_cmp_set),
		buv_set, bov_set});
	wire [15:0] irq_clr = wr_stat ? (wd16 & lane) : 16'h0000;
	wire [15:0] irq_stat_next =
		((irq_stat_reg & ~irq_clr) | irq_ev) & IRQ_MASK;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ov_en_reg <= REG_RESET;
			uv_en_reg <= REG_RESET;
			aux_en_reg <= REG_RESET;
			aux_cfg_reg <= REG_RESET;
			irq_stat_reg <= REG_RESET;
			irq_mask_reg <= REG_RESET;
		end else begin
			ov_en_reg <= ov_en_next;
			uv_en_reg <= uv_en_next;
			aux_en_reg <= aux_en_next;
			aux_cfg_reg <= aux_cfg_next;
			irq_stat_reg <= irq_stat_next;
			irq_mask_reg <= irq_mask_next;
		end
	end

	// Alert state and the registered outputs that mirror it
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			{bov_reg, buv_reg} <= 2'h0;
			{cov_adc_reg, cov_cmp_reg} <= '0;
			{cuv_adc_reg, cuv_cmp_reg} <= '0;
			{aov_adc_reg, aov_cmp_reg} <= '0;
			{block_over_alert, block_under_alert} <= 2'h0;
			{cell_over_alert, cell_under_alert} <= '0;
			aux_over_alert <= '0;
			irq <= 1'b0;
		end else begin
			{bov_reg, buv_reg} <= {bov_next, buv_next};
			{cov_adc_reg, cov_cmp_reg} <= {cov_adc_next, cov_cmp_next};
			{cuv_adc_reg, cuv_cmp_reg} <= {cuv_adc_next, cuv_cmp_next};
			{aov_adc_reg, aov_cmp_reg} <= {aov_adc_next, aov_cmp_next};
			block_over_alert <= bov_next;
			block_under_alert <= buv_next;
			cell_over_alert <= cov_adc_next | cov_cmp_next;
			cell_under_alert <= cuv_adc_next | cuv_cmp_next;
			aux_over_alert <= aov_adc_next | aov_cmp_next;
			irq <= |(irq_stat_next & irq_mask_next);
		end
	end

	// ------------------------------------------------------------
	// Read decode
	// ------------------------------------------------------------
	wire [IDX_W-1:0] ri = ra.rd_idx;
	wire [15:0] rd16 =
		(ri == IDX_OV_EN)    ? ov_en_reg :
		(ri == IDX_UV_EN)    ? uv_en_reg :
		(ri == IDX_AUX_EN)   ? aux_en_reg :
		(ri == IDX_AUX_CFG)  ? aux_cfg_reg :
		(ri == IDX_IRQ_STAT) ? irq_stat_reg :
		(ri == IDX_IRQ_MASK) ? irq_mask_reg :
		(ri == IDX_OV_ADC)   ? {1'b0, bov_reg, cov_adc_reg} :
		(ri == IDX_OV_CMP)   ? {2'h0, cov_cmp_reg} :
		(ri == IDX_UV_ADC)   ? {1'b0, buv_reg, cuv_adc_reg} :
		(ri == IDX_UV_CMP)   ? {2'h0, cuv_cmp_reg} :
		(ri == IDX_AUX_ALR)  ? {2'h0, aov_cmp_reg, 2'h0, aov_adc_reg} :
		16'h0000;
	assign ra.rd_data = {16'h0000, rd16};
	// Readable map: the three enables plus the block's own registers
	assign ra.rd_hit = (ri == IDX_OV_EN) || (ri == IDX_UV_EN) ||
		(ri == IDX_AUX_EN) ||
		((ri >= IDX_AUX_CFG) && (ri <= IDX_AUX_ALR));

	// ------------------------------------------------------------
	// Checks: no alert outlives its enable, irq follows status
	// ------------------------------------------------------------
	block_over_gate_a: assert property (
		@(posedge aclk) disable iff (!aresetn)
		block_over_alert |-> ov_en_reg[BLOCK_BIT])
		else $error("Block over alert without its enable");

	block_under_gate_a: assert property (
		@(posedge aclk) disable iff (!aresetn)
		block_under_alert |-> uv_en_reg[BLOCK_BIT])
		else $error("Block under alert without its enable");

	block_over_set_a: assert property (
		@(posedge aclk) disable iff (!aresetn)
		blk_meas && ov_en_reg[BLOCK_BIT] && !wr_ov &&
		(meas_adc > block_over_threshold) |=> block_over_alert)
		else $error("Block over measurement raised no alert");

	cell_over_gate_a: assert property (
		@(posedge aclk) disable iff (!aresetn)
		(cell_over_alert & ~ov_en_reg[CELL_N-1:0]) == '0)
		else $error("Cell over alert without its enable");

	cell_under_gate_a: assert property (
		@(posedge aclk) disable iff (!aresetn)
		(cell_under_alert & ~uv_en_reg[CELL_N-1:0]) == '0)
		else $error("Cell under alert without its enable");

	aux_over_gate_a: assert property (
		@(posedge aclk) disable iff (!aresetn)
		(aux_over_alert & ~aux_en_reg[AUX_N-1:0]) == '0)
		else $error("Aux over alert without its enable");

	unused_bits_a: assert property (
		@(posedge aclk) disable iff (!aresetn)
		!ov_en_reg[15] && !uv_en_reg[15] && (aux_en_reg[15:AUX_N] == '0))
		else $error("Unused enable bit is set");

	irq_level_a: assert property (
		@(posedge aclk) disable iff (!aresetn)
		irq == |(irq_stat_reg & irq_mask_reg))
		else $error("Interrupt line disagrees with status and mask");
endmodule // fault_check_top
`default_nettype wire

// [verilog/reg_access_if.sv]
/*
 Register access path between the bus slave and the register bank.
 Assumes one clock; the slave holds index and data while wr_en is high.
*/
`timescale 1ns/1ps
`default_nettype none
interface reg_access_if;
	import fault_check_pkg::*;
	logic             wr_en;
	logic [IDX_W-1:0] wr_idx;
	logic [31:0]      wr_data;
	logic [3:0]       wr_strb;
	logic             wr_hit;
	logic [IDX_W-1:0] rd_idx;
	logic [31:0]      rd_data;
	logic             rd_hit;
	modport bus (output wr_en, wr_idx, wr_data, wr_strb, rd_idx,
		input wr_hit, rd_data, rd_hit);
	modport regs (input wr_en, wr_idx, wr_data, wr_strb, rd_idx,
		output wr_hit, rd_data, rd_hit);
endinterface
`default_nettype wire
